// >>> design/gpt_map.svh
// gated prescaled timer: offsets, field positions, reset values
// assumes a 32-bit word-aligned register bus
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH

// register byte offsets
`define GPT_CTL_OFFSET    12'h000
`define GPT_CNT_OFFSET    12'h004

// control field positions
`define GPT_RUN_BIT       15
`define GPT_SIDL_BIT      13
`define GPT_GATE_BIT      6
`define GPT_PS_HI         5
`define GPT_PS_LO         4
`define GPT_SYNC_BIT      2
`define GPT_CS_BIT        1

// implemented control bits and reset values
`define GPT_CTL_MASK      16'hA076
`define GPT_CTL_RESET     16'h0000
`define GPT_CNT_RESET     16'h0000

// prescaler terminal counts (divide minus one)
`define GPT_TERM_DIV1     8'h00
`define GPT_TERM_DIV8     8'h07
`define GPT_TERM_DIV64    8'h3F
`define GPT_TERM_DIV256   8'hFF

// bus answers
`define GPT_RESP_OKAY     2'h0
`define GPT_RESP_SLVERR   2'h2

`endif

// >>> design/gpt_pkg.sv
// gated prescaled timer: shared types
// assumes gpt_map.svh for all numeric constants
package gpt_pkg;

    // prescale codes in register order
    typedef enum logic [1:0] {
        GPT_DIV1,
        GPT_DIV8,
        GPT_DIV64,
        GPT_DIV256
    } gpt_div_type;

endpackage

// >>> design/gpt_presc.sv
// gated prescaled timer: input clock prescaler
// assumes one-cycle source ticks synchronous to aclk
`timescale 1ns/1ps
`include "gpt_map.svh"

module gpt_presc (
    // clock, reset, clock enable
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // control
    input  wire logic              clear,
    input  wire gpt_pkg::gpt_div_type sel,
    // ticks
    input  wire logic              tick_in,
    output logic                   tick_out
);

    logic [7:0] div_reg;
    logic [7:0] div_next;
    wire  [7:0] term;
    wire        at_term;

    ////////////////////////////////////////////////////////////////////
    // terminal count per code
    assign term = (sel == gpt_pkg::GPT_DIV256) ? `GPT_TERM_DIV256 :
                  (sel == gpt_pkg::GPT_DIV64)  ? `GPT_TERM_DIV64  :
                  (sel == gpt_pkg::GPT_DIV8)   ? `GPT_TERM_DIV8   :
                                                 `GPT_TERM_DIV1;
    assign at_term  = (div_reg >= term);
    assign tick_out = tick_in && at_term;
    assign div_next = clear    ? 8'h00 :
                      !tick_in ? div_reg :
                      at_term  ? 8'h00 : div_reg + 8'h01;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg <= 8'h00;
        end else if (ce) begin
            div_reg <= div_next;
        end
    end

endmodule

// >>> design/gpt_timer.sv
// gated prescaled timer: control register, clock select, counter
// assumes an AXI4-Lite master on aclk, pins synchronous to aclk
`timescale 1ns/1ps
`include "gpt_map.svh"

module gpt_timer (
    // clock, reset, clock enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // write address channel
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // write response channel
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // read address channel
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // read data channel
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // timer pins and status
    input  wire logic        ext_clock_pin,
    input  wire logic        gate_pin,
    input  wire logic        idle_mode,
    output logic [15:0]      timer_count
);

    ////////////////////////////////////////////////////////////////////
    // state
    logic [15:0] ctl_reg;
    logic [15:0] ctl_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [11:0] awaddr_reg;
    logic        aw_full_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        w_full_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;
    logic        sync1_reg;
    logic        sync2_reg;
    logic        sync3_reg;
    logic        raw_prev_reg;

    ////////////////////////////////////////////////////////////////////
    // control fields
    wire run_bit             = ctl_reg[`GPT_RUN_BIT];
    wire stop_in_idle        = ctl_reg[`GPT_SIDL_BIT];
    wire gate_enable         = ctl_reg[`GPT_GATE_BIT];
    wire ext_clock_sync      = ctl_reg[`GPT_SYNC_BIT];
    wire clock_source_select = ctl_reg[`GPT_CS_BIT];
    wire gpt_pkg::gpt_div_type prescale_select =
        gpt_pkg::gpt_div_type'(ctl_reg[`GPT_PS_HI:`GPT_PS_LO]);

    ////////////////////////////////////////////////////////////////////
    // write path decode
    wire do_write = ce && aw_full_reg && w_full_reg && !bvalid_reg;
    wire wr_ctl   = do_write &&
                    (awaddr_reg[11:2] == 10'(`GPT_CTL_OFFSET >> 2));
    wire wr_cnt   = do_write &&
                    (awaddr_reg[11:2] == 10'(`GPT_CNT_OFFSET >> 2));
    wire wr_hit   = wr_ctl || wr_cnt;
    wire [15:0] lane_mask;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
            assign lane_mask[gi*8 +: 8] = {8{wstrb_reg[gi]}};
        end
    endgenerate

    wire [15:0] ctl_merge = (ctl_reg & ~lane_mask) |
                            (wdata_reg[15:0] & lane_mask);
    wire [15:0] cnt_merge = (cnt_reg & ~lane_mask) |
                            (wdata_reg[15:0] & lane_mask);

    // unimplemented control bits never store
    assign ctl_next = wr_ctl ? (ctl_merge & `GPT_CTL_MASK) : ctl_reg;

    ////////////////////////////////////////////////////////////////////
    // read path decode
    wire rd_take = ce && s_axi_arvalid && !rvalid_reg;
    wire rd_ctl  = (s_axi_araddr[11:2] == 10'(`GPT_CTL_OFFSET >> 2));
    wire rd_cnt  = (s_axi_araddr[11:2] == 10'(`GPT_CNT_OFFSET >> 2));
    wire [31:0] rd_mux = rd_ctl ? {16'h0000, ctl_reg & `GPT_CTL_MASK} :
                         rd_cnt ? {16'h0000, cnt_reg} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // count source selection
    wire ext_edge_sync = sync2_reg && !sync3_reg;
    wire ext_edge_raw  = ext_clock_pin && !raw_prev_reg;
    wire ext_edge      = ext_clock_sync ? ext_edge_sync :
                                          ext_edge_raw;
    wire int_tick      = gate_enable ? gate_pin : 1'b1;
    wire src_tick      = clock_source_select ? ext_edge : int_tick;
    wire idle_stop     = stop_in_idle && idle_mode;
    wire count_en      = run_bit && !idle_stop;
    wire presc_tick;

    gpt_presc u_presc (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ce       (ce),
        .clear    (!run_bit),
        .sel      (prescale_select),
        .tick_in  (src_tick && count_en),
        .tick_out (presc_tick)
    );

    // a software write to the count wins over a tick
    assign cnt_next = wr_cnt     ? cnt_merge :
                      presc_tick ? cnt_reg + 16'h0001 : cnt_reg;

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready = ce && !aw_full_reg && !bvalid_reg;
    assign s_axi_wready  = ce && !w_full_reg && !bvalid_reg;
    assign s_axi_arready = ce && !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign timer_count   = cnt_reg;

    ////////////////////////////////////////////////////////////////////
    // timer registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_reg <= `GPT_CTL_RESET;
            cnt_reg <= `GPT_CNT_RESET;
        end else if (ce) begin
            ctl_reg <= ctl_next;
            cnt_reg <= cnt_next;
        end
    end

    // external clock synchroniser and edge history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg    <= 1'b0;
            sync2_reg    <= 1'b0;
            sync3_reg    <= 1'b0;
            raw_prev_reg <= 1'b0;
        end else if (ce) begin
            sync1_reg    <= ext_clock_pin;
            sync2_reg    <= sync1_reg;
            sync3_reg    <= sync2_reg;
            raw_prev_reg <= ext_clock_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            awaddr_reg  <= 12'h000;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end else if (do_write) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `GPT_RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_hit ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= `GPT_RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (ce) begin
            if (rd_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_mux;
                rresp_reg  <= (rd_ctl || rd_cnt) ? `GPT_RESP_OKAY :
                                                   `GPT_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    property p_run_hold;
        @(posedge aclk) disable iff (!aresetn)
        (!run_bit && !wr_cnt) |=> (cnt_reg == $past(cnt_reg));
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("count moved while run bit clear");

    property p_idle_hold;
        @(posedge aclk) disable iff (!aresetn)
        (idle_mode && stop_in_idle && !wr_cnt) [*2] |=>
            (cnt_reg == $past(cnt_reg));
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("count moved in idle with stop-in-idle set");

    property p_gate_block;
        @(posedge aclk) disable iff (!aresetn)
        (!clock_source_select && gate_enable && !gate_pin) |-> !src_tick;
    endproperty
    a_gate_block: assert property (p_gate_block)
        else $error("internal tick passed a closed gate");

    property p_div1_step;
        @(posedge aclk) disable iff (!aresetn)
        (ce && count_en && src_tick && !wr_cnt &&
         prescale_select == gpt_pkg::GPT_DIV1)
            |=> (cnt_reg == $past(cnt_reg) + 16'h0001);
    endproperty
    a_div1_step: assert property (p_div1_step)
        else $error("undivided tick did not advance count");

    property p_sync_delay;
        @(posedge aclk) disable iff (!aresetn)
        (ce && clock_source_select && ext_clock_sync && count_en &&
         src_tick) |-> ($past(ext_clock_pin, 2) && !$past(ext_clock_pin, 3));
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("synchronised edge not two cycles behind pin");

    property p_unimpl_zero;
        @(posedge aclk) disable iff (!aresetn)
        (ce && s_axi_arvalid && !rvalid_reg && rd_ctl) |=>
            (s_axi_rdata[12:7] == 6'h00 && s_axi_rdata[14] == 1'b0);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented control bits read nonzero");

    property p_reset_ctl;
        @(posedge aclk)
        !aresetn |=> (ctl_reg == `GPT_CTL_RESET);
    endproperty
    a_reset_ctl: assert property (p_reset_ctl)
        else $error("control not cleared by reset");

    property p_idle_gate;
        @(posedge aclk) disable iff (!aresetn)
        (idle_mode && stop_in_idle) |-> !count_en ##1
            (!$past(presc_tick) || !$past(idle_mode));
    endproperty
    a_idle_gate: assert property (p_idle_gate)
        else $error("idle did not disable counting");

endmodule

// >>> testbench/gpt_pin_model.sv
// partner: external count clock and gate pin source
// assumes the bench clock; pins change just after rising edges
`timescale 1ns/1ps

module gpt_pin_model (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control from the bench
    input  wire logic clk_on,
    input  wire logic gate_on,
    input  int        half,
    // pins
    output logic      ext_clock_pin,
    output logic      gate_pin
);
    int cnt;
    int seed = 77;

    // clock stands low while switched off
    always @(posedge aclk) begin
        if (!aresetn || !clk_on) begin
            cnt <= 0;
            ext_clock_pin <= 1'b0;
        end else if (cnt + 1 >= half) begin
            cnt <= 0;
            ext_clock_pin <= ~ext_clock_pin;
        end else begin
            cnt <= cnt + 1;
        end
        gate_pin <= gate_on && ($random(seed) & 1);
    end
endmodule

// >>> testbench/tb_gated_prescaled_timer.sv
// bench: behavioural timer model compared with the design every cycle out of reset
// assumes gpt_timer, gpt_pin_model and the register map header
`timescale 1ns/1ps
`include "gpt_map.svh"

module tb_gated_prescaled_timer;
    logic        aclk, aresetn, ce, idle, clk_on, gate_on, pin, gate;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rsp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [15:0] count;
    int          half, seed, mismatches, comparisons;
    int          m_ctl, m_cnt, m_ps, pd, s1, s2, h_aw, h_w, w_a, w_d;
    int          divs[4] = '{1, 8, 64, 256};

    gpt_timer DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_clock_pin(pin), .gate_pin(gate), .idle_mode(idle),
        .timer_count(count));

    gpt_pin_model PIN (.aclk(aclk), .aresetn(aresetn), .clk_on(clk_on),
        .gate_on(gate_on), .half(half), .ext_clock_pin(pin),
        .gate_pin(gate));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////
    // reference model
    always @(posedge aclk) begin
        int tk;
        int raw;
        if (!aresetn) begin
            {m_ctl, m_cnt, m_ps, pd, s1, s2, h_aw, h_w} = '0;
        end else if (ce) begin
            raw = pin && !pd;
            tk = m_ctl[1] ? (m_ctl[2] ? s2 : raw) : (!m_ctl[6] || gate);
            s2 = s1;
            s1 = raw;
            pd = pin;
            if (!m_ctl[15]) begin
                m_ps = 0;
            end else if (tk && !(idle && m_ctl[13])) begin
                m_ps = m_ps + 1;
                if (m_ps >= divs[m_ctl[5:4]]) begin
                    m_ps = 0;
                    m_cnt = (m_cnt + 1) & 16'hFFFF;
                end
            end
            if (h_aw && h_w) begin
                if (w_a == `GPT_CTL_OFFSET) m_ctl = w_d & `GPT_CTL_MASK;
                else if (w_a == `GPT_CNT_OFFSET) m_cnt = w_d & 16'hFFFF;
                h_aw = 0;
                h_w = 0;
            end
            if (awvalid && awready) begin
                h_aw = 1;
                w_a = awaddr;
            end
            if (wvalid && wready) begin
                h_w = 1;
                w_d = wdata;
            end
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    always @(negedge aclk) begin
        if (aresetn) check(count, m_cnt);
    end

    ////////////////////////////////////////////////////////////////////
    // bus tasks
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        check(bresp, er);
    endtask

    task automatic rdw(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        rsp = rresp;
    endtask

    task automatic run(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        run(20000);
        mismatches++;
        wrap_up;
    end

    ////////////////////////////////////////////////////////////////////
    // scenarios
    initial begin
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready, idle, gate_on} = '0;
        {clk_on, aresetn} = '0;
        ce = 1'b1;
        seed = 77;
        half = 2;
        run(5);
        aresetn <= 1'b1;
        run(1);
        rdw(12'h000);
        check(rd, 0);
        check(rsp, `GPT_RESP_OKAY);
        rdw(12'h004);
        check(rd, 0);
        done("reset");
        wr(12'h000, 32'h0000_5F88, 2'h0);
        rdw(12'h000);
        check(rd, 0);
        wr(12'h008, 32'h0000_1234, 2'h2);
        rdw(12'h008);
        check(rd, 0);
        check(rsp, 2'h2);
        done("map");
        wr(12'h000, 32'h0000_8000, 2'h0);
        run(20);
        wr(12'h004, $random(seed), 2'h0);
        run(20);
        for (int p = 0; p < 4; p++) begin
            wr(12'h000, 32'h0000_8000 | (p << 4), 2'h0);
            run(540);
            wr(12'h000, 32'h0, 2'h0);
            run(10);
            rdw(12'h004);
            check(rd, m_cnt);
        end
        // prescale code changed while running, prescaler not cleared
        wr(`GPT_CTL_OFFSET, 32'h0000_8030, 2'h0);
        run(100);
        wr(`GPT_CTL_OFFSET, 32'h0000_8010, 2'h0);
        run(30);
        done("prescale");
        gate_on <= 1'b1;
        wr(12'h000, 32'h0000_8040, 2'h0);
        run(200);
        wr(12'h000, 32'h0000_8044, 2'h0);
        run(100);
        clk_on <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            half <= 1 + ($random(seed) & 3);
            wr(12'h000, 32'h8002 | ((m & 1) << 2) | ((m >> 1) << 6),
               2'h0);
            run(300);
        end
        done("sources");
        clk_on <= 1'b0;
        idle <= 1'b1;
        wr(12'h000, 32'h0000_8000, 2'h0);
        run(50);
        wr(12'h000, 32'h0000_A000, 2'h0);
        run(50);
        idle <= 1'b0;
        run(20);
        done("idle");
        for (int i = 0; i < 200; i++) begin
            ce <= $random(seed) & 1;
            run(1);
        end
        ce <= 1'b1;
        wr(12'h000, 32'h0, 2'h0);
        rdw(12'h004);
        check(rd, m_cnt);
        done("enable");
        wrap_up;
    end
endmodule
